//--- rtl/ucr_pkg.sv
// Purpose: constants and types for the uart control block
// Assumes: apb byte addresses, one word per register
// Notes:   register fields hold only low bits of each word
package ucr_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL1  = 8'h00;
    localparam logic [7:0] ADDR_CTRL2  = 8'h04;
    localparam logic [7:0] ADDR_CTRL3  = 8'h08;
    localparam logic [7:0] ADDR_DATA   = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_BAUD   = 8'h14;
    // control one and control three field positions
    localparam int         POS_GLOB    = 7;
    localparam int         POS_DLS     = 6;
    localparam int         POS_RX9     = 1;
    localparam int         POS_TX9     = 0;
    localparam int         POS_SWSEL   = 0;
    // reset values
    localparam logic [7:0]  CTRL2_RST  = 8'h00;
    localparam logic [15:0] BAUD_RST   = 16'h0010;
    // frame lengths
    localparam logic [3:0] BITS_8      = 4'h8;
    localparam logic [3:0] BITS_9      = 4'h9;

    // second control register, bit 7 first
    typedef struct packed {
        logic transmitter_enable;
        logic receiver_enable;
        logic stop_count_select;
        logic address_detect_enable;
        logic wake_enable;
        logic receive_irq_enable;
        logic tx_idle_irq_enable;
        logic tx_empty_irq_enable;
    } ucr_ctrl2_s;

    // serial engine states, gray along idle-start-data-stop
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_DATA  = 2'b11,
        ST_STOP  = 2'b10
    } ucr_state_e;
endpackage

//--- rtl/ucr_uart.sv
// Purpose: uart with enable, stop, address detect, wake and irq control
// Assumes: pins synchronous to pclk, apb zero wait state slave
// Notes:   uart_clk_off marks the uart clock switched off
// Summary of operation
// - transmitter enable low: transmitter off, frame aborted, buffer cleared, tx floats
// - tx pin driven only when transmitter and global enable both set
// - clearing transmitter enable mid frame aborts it and floats tx
// - receiver enable low: receiver off, reception aborted, buffer cleared, pin floats unless single wire transmitter drives it
// - receiver works and owns shared pin only with global enable set
// - clearing receiver enable mid frame aborts reception and floats pin, unless single wire transmitter then drives it
// - stop count select gives two stop bits, else one
// - with address detect, top bit one marks an address word
// - address word with receive irq enabled raises the irq
// - with address detect, data words are dropped without irq
// - pin wake works only while the uart clock is off
// - wake enabled, clock off: falling edge raises wake, irq if enabled
// - wake disabled: falling edges ignored while clock off
// - receive irq enable passes overrun and rx available to irq
// - tx idle irq enable passes tx idle flag to irq
// - tx empty irq enable passes tx empty flag to irq
// - data length select picks 8 or 9 bits with ninth-bit holders
// - clearing global enable ends frames, resets module, clears both enables, keeps other configuration
// - single wire with both enables: shared pin is receiver input only
`timescale 1ns/1ps
module ucr_uart import ucr_pkg::*; (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        uart_clk_off,
    input  wire logic        rxtx_in,
    output logic             rxtx_out,
    output logic             rxtx_oe,
    output logic             tx_out,
    output logic             tx_oe,
    output logic             wake_req,
    output logic             uart_irq
);
    ucr_ctrl2_s  ctrl_reg;
    logic        glob_reg, dls_reg, tx9_reg, swsel_reg;
    logic [15:0] baud_reg, tx_cnt_reg, rx_cnt_reg;
    logic [8:0]  txbuf_reg, txsh_reg, rxsh_reg, rxdat_reg;
    logic        txfull_reg, avail_reg, ovr_reg, rx_q_reg, rx_qq_reg;
    logic [3:0]  tx_bit_reg, rx_bit_reg;
    ucr_state_e  tx_st_reg, rx_st_reg;

    function automatic logic [8:0] frame_word(input logic dls, input logic [8:0] sh);
        frame_word = dls ? sh : {1'b0, sh[8:1]};
    endfunction

    // apb decode
    wire acc    = psel & penable & pready;
    wire wr     = acc & pwrite;
    wire rd     = acc & ~pwrite;
    wire hit    = paddr inside {ADDR_CTRL1, ADDR_CTRL2, ADDR_CTRL3, ADDR_DATA, ADDR_STATUS, ADDR_BAUD};
    wire wr_c1  = wr & (paddr == ADDR_CTRL1);
    wire wr_c2  = wr & (paddr == ADDR_CTRL2);
    wire wr_dat = wr & (paddr == ADDR_DATA);
    wire rd_dat = rd & (paddr == ADDR_DATA);
    wire rd_sts = rd & (paddr == ADDR_STATUS);

    // enables and pin ownership
    wire tx_on  = glob_reg & ctrl_reg.transmitter_enable;
    wire rx_on  = glob_reg & ctrl_reg.receiver_enable;
    wire tx_pin = tx_on & ~swsel_reg;
    wire sw_tx  = swsel_reg & tx_on & ~rx_on;
    wire [3:0] nbits = dls_reg ? BITS_9 : BITS_8;

    // status flags
    wire tx_empty = ~txfull_reg;
    wire tx_idle  = (tx_st_reg == ST_IDLE) & ~txfull_reg;

    // transmit timing
    wire tx_tick = (tx_cnt_reg == baud_reg - 16'h0001);
    wire tx_load = tx_on & (tx_st_reg == ST_IDLE) & txfull_reg;

    // receive timing and delivery
    wire rx_fall  = rx_qq_reg & ~rx_q_reg;
    wire rx_mid   = (rx_cnt_reg == {1'b0, baud_reg[15:1]});
    wire rx_full  = (rx_cnt_reg == baud_reg - 16'h0001);
    wire [8:0] rx_word = frame_word(dls_reg, rxsh_reg);
    wire addr_bit = dls_reg ? rx_word[8] : rx_word[7];
    wire rx_done  = (rx_st_reg == ST_STOP) & rx_full;
    wire deliver  = rx_done & (~ctrl_reg.address_detect_enable | addr_bit);
    wire fall_wk  = uart_clk_off & ctrl_reg.wake_enable & rx_fall;

    // interrupt sources
    wire irq_src = (ctrl_reg.receive_irq_enable & (avail_reg | ovr_reg | wake_req))
                 | (ctrl_reg.tx_idle_irq_enable & tx_idle)
                 | (ctrl_reg.tx_empty_irq_enable & tx_empty);

    // read mux
    wire [31:0] rdata =
        (paddr == ADDR_CTRL1)  ? {24'h0, glob_reg, dls_reg, 4'h0, rxdat_reg[8], 1'b0} :
        (paddr == ADDR_CTRL2)  ? {24'h0, ctrl_reg} :
        (paddr == ADDR_CTRL3)  ? {31'h0, swsel_reg} :
        (paddr == ADDR_DATA)   ? {24'h0, rxdat_reg[7:0]} :
        (paddr == ADDR_STATUS) ? {27'h0, wake_req, ovr_reg, avail_reg, tx_idle, tx_empty} :
        (paddr == ADDR_BAUD)   ? {16'h0, baud_reg} : 32'h0;

    // apb answer in first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable & ~pready;
            prdata  <= rdata;
            pslverr <= psel & ~penable & ~hit;
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            glob_reg <= 1'b0;
            dls_reg  <= 1'b0;
            tx9_reg  <= 1'b0;
            swsel_reg <= 1'b0;
            ctrl_reg <= CTRL2_RST;
            baud_reg <= BAUD_RST;
        end else begin
            if (wr_c1) begin
                glob_reg <= pwdata[POS_GLOB];
                dls_reg  <= pwdata[POS_DLS];
                tx9_reg  <= pwdata[POS_TX9];
            end
            if (wr_c2)
                ctrl_reg <= ucr_ctrl2_s'(pwdata[7:0]);
            if (wr & (paddr == ADDR_CTRL3))
                swsel_reg <= pwdata[POS_SWSEL];
            if (wr & (paddr == ADDR_BAUD))
                baud_reg <= pwdata[15:0];
            if (wr_c1 & ~pwdata[POS_GLOB]) begin
                ctrl_reg.transmitter_enable <= 1'b0;
                ctrl_reg.receiver_enable    <= 1'b0;
            end
        end
    end

    // transmitter: buffer, shifter and frame sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txbuf_reg  <= 9'h0;
            txfull_reg <= 1'b0;
            txsh_reg   <= 9'h0;
            tx_cnt_reg <= 16'h0;
            tx_bit_reg <= 4'h0;
            tx_st_reg  <= ST_IDLE;
            tx_out     <= 1'b1;
        end else if (!tx_on) begin
            txfull_reg <= 1'b0;
            tx_cnt_reg <= 16'h0;
            tx_bit_reg <= 4'h0;
            tx_st_reg  <= ST_IDLE;
            tx_out     <= 1'b1;
        end else begin
            if (wr_dat & txfull_reg == 1'b0) begin
                txbuf_reg  <= {tx9_reg, pwdata[7:0]};
                txfull_reg <= 1'b1;
            end
            tx_cnt_reg <= (tx_st_reg == ST_IDLE || tx_tick) ? 16'h0 : tx_cnt_reg + 16'h0001;
            if (tx_load) begin
                txsh_reg   <= txbuf_reg;
                txfull_reg <= 1'b0;
                tx_st_reg  <= ST_START;
                tx_out     <= 1'b0;
            end else if (tx_tick) begin
                unique case (tx_st_reg)
                    ST_START: begin
                        tx_out     <= txsh_reg[0];
                        txsh_reg   <= {1'b0, txsh_reg[8:1]};
                        tx_bit_reg <= 4'h1;
                        tx_st_reg  <= ST_DATA;
                    end
                    ST_DATA: begin
                        if (tx_bit_reg == nbits) begin
                            tx_out     <= 1'b1;
                            tx_bit_reg <= 4'h0;
                            tx_st_reg  <= ST_STOP;
                        end else begin
                            tx_out     <= txsh_reg[0];
                            txsh_reg   <= {1'b0, txsh_reg[8:1]};
                            tx_bit_reg <= tx_bit_reg + 4'h1;
                        end
                    end
                    ST_STOP: begin
                        if (tx_bit_reg == {3'h0, ctrl_reg.stop_count_select})
                            tx_st_reg <= ST_IDLE;
                        tx_bit_reg <= tx_bit_reg + 4'h1;
                    end
                    ST_IDLE: tx_out <= 1'b1;
                endcase
            end
        end
    end

    // receiver: start detect, mid-bit sampling, delivery
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_q_reg   <= 1'b1;
            rx_qq_reg  <= 1'b1;
            rxsh_reg   <= 9'h0;
            rxdat_reg  <= 9'h0;
            avail_reg  <= 1'b0;
            ovr_reg    <= 1'b0;
            rx_cnt_reg <= 16'h0;
            rx_bit_reg <= 4'h0;
            rx_st_reg  <= ST_IDLE;
        end else begin
            rx_q_reg  <= rxtx_in;
            rx_qq_reg <= rx_q_reg;
            if (!rx_on) begin
                avail_reg  <= 1'b0;
                ovr_reg    <= 1'b0;
                rx_cnt_reg <= 16'h0;
                rx_bit_reg <= 4'h0;
                rx_st_reg  <= ST_IDLE;
            end else begin
                // new word wins over a clearing read
                avail_reg  <= deliver | (avail_reg & ~rd_dat);
                ovr_reg    <= (deliver & avail_reg & ~rd_dat) | (ovr_reg & ~rd_sts);
                if (deliver)
                    rxdat_reg <= rx_word;
                rx_cnt_reg <= (rx_st_reg == ST_IDLE || (rx_st_reg == ST_START ? rx_mid : rx_full))
                              ? 16'h0 : rx_cnt_reg + 16'h0001;
                unique case (rx_st_reg)
                    ST_IDLE:
                        if (rx_fall & ~uart_clk_off)
                            rx_st_reg <= ST_START;
                    ST_START:
                        if (rx_mid) begin
                            rx_bit_reg <= 4'h0;
                            rx_st_reg  <= rx_q_reg ? ST_IDLE : ST_DATA;
                        end
                    ST_DATA:
                        if (rx_full) begin
                            rxsh_reg   <= {rx_q_reg, rxsh_reg[8:1]};
                            rx_bit_reg <= rx_bit_reg + 4'h1;
                            if (rx_bit_reg == nbits - 4'h1)
                                rx_st_reg <= ST_STOP;
                        end
                    ST_STOP:
                        if (rx_full)
                            rx_st_reg <= ST_IDLE;
                endcase
            end
        end
    end

    // pins, wake and interrupt outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_oe    <= 1'b0;
            rxtx_oe  <= 1'b0;
            rxtx_out <= 1'b1;
            wake_req <= 1'b0;
            uart_irq <= 1'b0;
        end else begin
            tx_oe    <= tx_pin;
            rxtx_oe  <= sw_tx;
            rxtx_out <= tx_out;
            wake_req <= uart_clk_off & (fall_wk | wake_req);
            uart_irq <= irq_src;
        end
    end

    // checks
    property p_tx_float;
        @(posedge pclk) disable iff (!presetn) !tx_on |=> !tx_oe;
    endproperty
    a_tx_float: assert property (p_tx_float) else $error("tx pin driven while disabled");

    property p_tx_drive;
        @(posedge pclk) disable iff (!presetn) tx_oe |-> $past(glob_reg) && $past(ctrl_reg.transmitter_enable);
    endproperty
    a_tx_drive: assert property (p_tx_drive) else $error("tx driven without both enables");

    property p_tx_abort;
        @(posedge pclk) disable iff (!presetn)
            tx_st_reg != ST_IDLE && !tx_on |=> tx_st_reg == ST_IDLE && !txfull_reg && tx_out;
    endproperty
    a_tx_abort: assert property (p_tx_abort) else $error("tx frame not aborted");

    property p_rx_abort;
        @(posedge pclk) disable iff (!presetn) !rx_on |=> rx_st_reg == ST_IDLE && !avail_reg && !ovr_reg;
    endproperty
    a_rx_abort: assert property (p_rx_abort) else $error("rx not reset when disabled");

    property p_two_stop;
        @(posedge pclk) disable iff (!presetn)
            tx_on && tx_st_reg == ST_STOP && tx_tick && tx_bit_reg == 4'h0 && ctrl_reg.stop_count_select
            |=> tx_st_reg == ST_STOP;
    endproperty
    a_two_stop: assert property (p_two_stop) else $error("second stop bit missing");

    property p_drop_data;
        @(posedge pclk) disable iff (!presetn)
            rx_on && rx_done && ctrl_reg.address_detect_enable && !addr_bit && !avail_reg |=> !avail_reg;
    endproperty
    a_drop_data: assert property (p_drop_data) else $error("data word kept under address detect");

    property p_wake;
        @(posedge pclk) disable iff (!presetn) fall_wk ##1 uart_clk_off |-> wake_req;
    endproperty
    a_wake: assert property (p_wake) else $error("wake not raised");

    property p_no_wake;
        @(posedge pclk) disable iff (!presetn) !uart_clk_off |=> !wake_req;
    endproperty
    a_no_wake: assert property (p_no_wake) else $error("wake while clock runs");

    property p_rx_irq;
        @(posedge pclk) disable iff (!presetn) ctrl_reg.receive_irq_enable && avail_reg |=> uart_irq;
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("rx irq missing");

    property p_sw_rx;
        @(posedge pclk) disable iff (!presetn) swsel_reg && rx_on |=> !rxtx_oe && !tx_oe;
    endproperty
    a_sw_rx: assert property (p_sw_rx) else $error("shared pin driven in receive");

    c_frame: cover property (@(posedge pclk) disable iff (!presetn) tx_st_reg == ST_STOP ##1 tx_st_reg == ST_IDLE);
    c_addr:  cover property (@(posedge pclk) disable iff (!presetn) deliver && ctrl_reg.address_detect_enable);
    c_wake:  cover property (@(posedge pclk) disable iff (!presetn) $rose(wake_req));
endmodule

//--- bench/ucr_node.sv
// Purpose: remote serial node driving the shared rx/tx pin
// Assumes: line idles high, lsb first, one stop bit
// Notes:   bit time is given in pclk cycles by the caller
`timescale 1ns/1ps
module ucr_node (
    input  wire logic pclk,
    output logic      line
);
    // idle level until the first frame
    initial begin
        line = 1'b1;
    end

    // one frame: start low, data lsb first, stop high, then idle
    task automatic send(input logic [8:0] w, input int nb, input int bt);
        for (int i = 0; i < nb + 2; i++) begin
            @(posedge pclk);
            line <= (i == 0) ? 1'b0 : (i > nb) ? 1'b1 : w[i-1];
            repeat (bt - 1) @(posedge pclk);
        end
        repeat (bt) @(posedge pclk);
    endtask
endmodule

//--- bench/uart_txrx_enable_irq_control_bench.sv
// Purpose: self-checking bench for the uart control block
// Assumes: zero wait apb slave, pull-up on the tx pin
// Notes:   baud divider set to 4 to keep frames short
`timescale 1ns/1ps
module uart_txrx_enable_irq_control_bench import ucr_pkg::*;;
    localparam int BT = 4;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        clk_off;
    logic        rxtx_out;
    logic        rxtx_oe;
    logic        tx_out;
    logic        tx_oe;
    logic        wake_req;
    logic        uart_irq;
    logic        node_line;
    logic [31:0] rdata;
    logic        rerr;
    int          err_count = 0;
    int          n_compared = 0;
    int          lows;
    logic [7:0]  en_tab [4] = '{8'h02, 8'h01, 8'h04, 8'h00};
    logic [3:0]  irq_tab = 4'b0011;

    // pin levels seen by all parties
    wire tx_pin   = tx_oe ? tx_out : 1'b1;
    wire rxtx_pin = rxtx_oe ? rxtx_out : node_line;

    ucr_uart dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .uart_clk_off(clk_off), .rxtx_in(rxtx_pin), .rxtx_out(rxtx_out), .rxtx_oe(rxtx_oe),
        .tx_out(tx_out), .tx_oe(tx_oe), .wake_req(wake_req), .uart_irq(uart_irq)
    );
    ucr_node node_u (.pclk(pclk), .line(node_line));

    // clock generation
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic end_of_test;
        if (err_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) cmp(0, 1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        cmp(rdata & m, e);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic rx(input logic [8:0] w, input int nb);
        node_u.send(w, nb, BT);
        cyc(6);
    endtask

    // checks one frame on the tx pin, then, when more is set, the gap to the next start
    task automatic frame(input logic [7:0] d, input logic two, input logic more);
        int n;
        n = 0;
        while (tx_pin !== 1'b0 && n < 400) begin
            @(negedge pclk);
            n++;
        end
        repeat (2) @(negedge pclk);
        cmp(tx_pin, 0);
        for (int i = 0; i < 8; i++) begin
            repeat (BT) @(negedge pclk);
            cmp(tx_pin, d[i]);
        end
        repeat (BT) @(negedge pclk);
        cmp(tx_pin, 1);
        n = 0;
        while (more && tx_pin !== 1'b0 && n < 20) begin
            @(negedge pclk);
            n++;
        end
        if (more) cmp(two ? (n >= 6 && n <= 10) : (n >= 1 && n <= 5), 1);
    endtask

    // watchdog
    initial begin
        #100000;
        err_count++;
        end_of_test;
    end

    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        clk_off = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_CTRL2, 32'hff, {24'h0, CTRL2_RST});
        rd(ADDR_BAUD, 32'hffff, {16'h0, BAUD_RST});
        rd(8'h3c, 32'hffffffff, 0);
        cmp(rerr, 1);
        wr(ADDR_CTRL2, 32'hff);
        rd(ADDR_CTRL2, 32'hffffffff, 32'hff);
        cyc(3);
        cmp(tx_oe, 0);
        wr(ADDR_BAUD, BT);
        wr(ADDR_CTRL1, 32'h80);
        cyc(3);
        cmp(tx_oe, 1);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CTRL2, en_tab[i]);
            cyc(3);
            cmp(uart_irq, irq_tab[i]);
        end
        cmp(tx_oe, 0);
        // one and two stop bits, second byte buffered
        for (int s = 0; s < 2; s++) begin
            wr(ADDR_CTRL2, s ? 32'ha0 : 32'h80);
            fork
                frame(8'ha5, s[0], 1'b1);
                begin
                    wr(ADDR_DATA, 32'ha5);
                    wr(ADDR_DATA, 32'h3c);
                end
            join
            frame(8'h3c, s[0], 1'b0);
        end
        // abort mid frame, buffered byte must be dropped
        // let the last frame finish so that both writes are taken
        cyc(8);
        wr(ADDR_DATA, 32'h00);
        wr(ADDR_DATA, 32'h00);
        cyc(6);
        wr(ADDR_CTRL2, 32'h00);
        cyc(3);
        cmp({tx_oe, tx_out}, 2'b01);
        wr(ADDR_CTRL2, 32'h80);
        lows = 0;
        repeat (80) begin
            @(negedge pclk);
            lows += (tx_pin === 1'b0);
        end
        cmp(lows, 0);
        // global disable mid frame clears the enables, keeps other configuration
        wr(ADDR_CTRL2, 32'ha0);
        wr(ADDR_DATA, 32'h00);
        cyc(8);
        wr(ADDR_CTRL1, 32'h00);
        cyc(3);
        cmp(tx_oe, 0);
        rd(ADDR_CTRL2, 32'hff, 32'h20);
        rd(ADDR_STATUS, 32'h3, 32'h3);
        wr(ADDR_CTRL1, 32'h80);
        // address detect in 8-bit format
        wr(ADDR_CTRL2, 32'h54);
        rx(9'h035, 8);
        cmp(uart_irq, 0);
        rd(ADDR_STATUS, 32'h4, 0);
        rx(9'h08a, 8);
        cmp(uart_irq, 1);
        cmp(rxtx_oe, 0);
        rd(ADDR_DATA, 32'hff, 32'h8a);
        cyc(2);
        cmp(uart_irq, 0);
        // overrun with receive irq masked, then unmasked
        wr(ADDR_CTRL2, 32'h40);
        rx(9'h011, 8);
        rx(9'h022, 8);
        cmp(uart_irq, 0);
        wr(ADDR_CTRL2, 32'h44);
        cyc(3);
        cmp(uart_irq, 1);
        rd(ADDR_STATUS, 32'hc, 32'hc);
        apb(1'b0, ADDR_DATA, 32'h0);
        // address bit is the ninth bit in 9-bit format
        wr(ADDR_CTRL1, 32'hc0);
        wr(ADDR_CTRL2, 32'h54);
        rx(9'h0ff, 9);
        cmp(uart_irq, 0);
        rx(9'h155, 9);
        cmp(uart_irq, 1);
        rd(ADDR_CTRL1, 32'h2, 32'h2);
        rd(ADDR_DATA, 32'hff, 32'h55);
        wr(ADDR_CTRL1, 32'h80);
        // receiver disabled mid character
        wr(ADDR_CTRL2, 32'h40);
        fork
            node_u.send(9'h00f, 8, BT);
            begin
                cyc(20);
                wr(ADDR_CTRL2, 32'h00);
            end
        join
        cmp(rxtx_oe, 0);
        wr(ADDR_CTRL2, 32'h40);
        cyc(BT * 12);
        rd(ADDR_STATUS, 32'h4, 0);
        // pin wake only with clock off and wake set
        clk_off <= 1'b1;
        wr(ADDR_CTRL2, 32'h04);
        rx(9'h000, 8);
        cmp(wake_req, 0);
        wr(ADDR_CTRL2, 32'h0c);
        rx(9'h000, 8);
        cmp({wake_req, uart_irq}, 2'b11);
        clk_off <= 1'b0;
        cyc(3);
        cmp(wake_req, 0);
        rx(9'h000, 8);
        cmp(wake_req, 0);
        // single wire: both enables leave the shared pin as input
        wr(ADDR_CTRL3, 32'h1);
        wr(ADDR_CTRL2, 32'hc0);
        cyc(3);
        cmp(rxtx_oe, 0);
        wr(ADDR_CTRL2, 32'h80);
        cyc(3);
        cmp({rxtx_oe, tx_oe}, 2'b10);
        // start bit leaves on the shared pin one cycle after tx line
        wr(ADDR_DATA, 32'h00);
        cyc(3);
        cmp({rxtx_oe, rxtx_out}, 2'b10);
        end_of_test;
    end
endmodule
